// File: rtl/dsd_pkg.sv
package dsd_pkg;

  // ************************************************************
  // Data-space map
  // ************************************************************
  localparam logic [7:0] DSD_BIT_BASE = 8'h20;
  localparam logic [7:0] DSD_SP_ADDR = 8'h81;
  localparam logic [7:0] DSD_PAGE_ADDR = 8'h84;
  localparam logic [7:0] DSD_NEXT_ADDR = 8'h85;
  localparam logic [7:0] DSD_LAST_ADDR = 8'h86;
  localparam logic [7:0] DSD_PGCN_ADDR = 8'h96;
  localparam logic [7:0] DSD_P0_ADDR = 8'h80;
  localparam logic [7:0] DSD_P1_ADDR = 8'h90;
  localparam logic [7:0] DSD_P2_ADDR = 8'hA0;
  localparam logic [7:0] DSD_P3_ADDR = 8'hB0;

  // ************************************************************
  // Implemented pages
  // ************************************************************
  localparam logic [7:0] DSD_PAGE_0 = 8'h00;
  localparam logic [7:0] DSD_PAGE_1 = 8'h01;
  localparam logic [7:0] DSD_PAGE_2 = 8'h02;
  localparam logic [7:0] DSD_PAGE_3 = 8'h03;
  localparam logic [7:0] DSD_PAGE_F = 8'h0F;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] DSD_SP_RST = 8'h07;
  localparam logic [7:0] DSD_PAGE_RST = 8'h00;
  localparam logic [7:0] DSD_EMPTY_PAGE = 8'h00;
  localparam logic DSD_PGEN_RST = 1'b1;
  localparam logic [7:0] DSD_PORT_RST = 8'hFF;

  // ************************************************************
  // Stack record
  // ************************************************************
  localparam int DSD_REC_W = 32;
  localparam logic [5:0] DSD_REC_FULL = 6'h20;

  typedef enum logic [1:0] {
    DSD_IDLE = 2'b00,
    DSD_CALL_HI = 2'b01,
    DSD_RET_LO = 2'b10
  } dsd_state_t;

endpackage

// File: rtl/dsd_ram.sv
`timescale 1ns/1ps
module dsd_ram
(
  input wire logic clk,
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] raddr,
  output logic [7:0] rdata
);

  // ************************************************************
  // Storage
  // ************************************************************
  typedef struct packed {
    logic [255:0][7:0] mem;
  } dsd_ram_t;

  dsd_ram_t ram_reg;
  dsd_ram_t ram_next;

  // Contents are not cleared; software initialises its own data
  always_comb
  begin
    ram_next = ram_reg;
    if (we)
    begin
      ram_next.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    ram_reg <= ram_next;
  end

  assign rdata = ram_reg.mem[raddr];

endmodule

// File: rtl/dsd_stkrec.sv
`timescale 1ns/1ps
module dsd_stkrec
  import dsd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_one,
  input wire logic in_two,
  input wire logic out_one,
  input wire logic out_two,
  output logic [DSD_REC_W-1:0] rec_bits,
  output logic [5:0] rec_level,
  output logic rec_overflow,
  output logic rec_underflow
);

  typedef struct packed {
    logic [DSD_REC_W-1:0] bits;
    logic [5:0] level;
    logic ovf;
    logic unf;
  } dsd_rec_t;

  dsd_rec_t rec_reg;
  dsd_rec_t rec_next;

  // ************************************************************
  // Shift record
  // ************************************************************
  always_comb
  begin
    rec_next = rec_reg;
    rec_next.ovf = 1'b0;
    rec_next.unf = 1'b0;
    if (in_one)
    begin
      rec_next.bits = {rec_reg.bits[DSD_REC_W-2:0], 1'b0};
      if (rec_reg.level == DSD_REC_FULL)
        rec_next.ovf = 1'b1;
      else
        rec_next.level = rec_reg.level + 6'h01;
    end
    else if (in_two)
    begin
      rec_next.bits = {rec_reg.bits[DSD_REC_W-3:0], 2'b11};
      if (rec_reg.level > DSD_REC_FULL - 6'h02)
      begin
        rec_next.ovf = 1'b1;
        rec_next.level = DSD_REC_FULL;
      end
      else
        rec_next.level = rec_reg.level + 6'h02;
    end
    else if (out_one)
    begin
      rec_next.bits = {1'b0, rec_reg.bits[DSD_REC_W-1:1]};
      if (rec_reg.level == 6'h00)
        rec_next.unf = 1'b1;
      else
        rec_next.level = rec_reg.level - 6'h01;
    end
    else if (out_two)
    begin
      rec_next.bits = {2'b00, rec_reg.bits[DSD_REC_W-1:2]};
      if (rec_reg.level < 6'h02)
      begin
        rec_next.unf = 1'b1;
        rec_next.level = 6'h00;
      end
      else
        rec_next.level = rec_reg.level - 6'h02;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rec_reg <= '0;
    else
      rec_reg <= rec_next;
  end

  assign rec_bits = rec_reg.bits;
  assign rec_level = rec_reg.level;
  assign rec_overflow = rec_reg.ovf;
  assign rec_underflow = rec_reg.unf;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_rec_ovf;
    @(posedge clk) disable iff (sys_rst)
    (in_one && rec_level == DSD_REC_FULL) |=> rec_overflow && rec_level == DSD_REC_FULL;
  endproperty
  a_rec_ovf: assert property (p_rec_ovf) else $error("record overflow missed");

  property p_rec_call;
    @(posedge clk) disable iff (sys_rst)
    (!in_one && in_two && rec_level < 6'h1E) |=> rec_level == $past(rec_level) + 6'h02;
  endproperty
  a_rec_call: assert property (p_rec_call) else $error("call did not add two bits");

  property p_rec_ret;
    @(posedge clk) disable iff (sys_rst)
    (!in_one && !in_two && !out_one && out_two && rec_level < 6'h02) |=> rec_underflow;
  endproperty
  a_rec_ret: assert property (p_rec_ret) else $error("record underflow missed");

endmodule

// File: rtl/dsd_core.sv
`timescale 1ns/1ps
module dsd_core
  import dsd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_bit,
  input wire logic acc_indirect,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic stk_call,
  input wire logic stk_ret,
  input wire logic [7:0] push_data,
  input wire logic [15:0] call_addr,
  input wire logic irq_enter,
  input wire logic [7:0] irq_page,
  input wire logic return_from_interrupt,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [15:0] ret_addr,
  output logic ret_valid,
  output logic busy,
  output logic [7:0] stack_pointer,
  output logic [7:0] page_select_register,
  output logic [7:0] page_stack_second_entry,
  output logic [7:0] page_stack_bottom_entry,
  output logic auto_page_enable,
  output logic [7:0] port_zero_data,
  output logic [7:0] port_one_data,
  output logic [7:0] port_two_data,
  output logic [7:0] port_three_data,
  output logic ext_sfr_valid,
  output logic ext_sfr_write,
  output logic [7:0] ext_sfr_addr,
  output logic [7:0] ext_sfr_page,
  output logic [7:0] ext_sfr_wdata,
  output logic [5:0] rec_level,
  output logic rec_overflow,
  output logic rec_underflow
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    dsd_state_t state;
    logic busy;
    logic [7:0] sp;
    logic [7:0] page;
    logic [7:0] nxt;
    logic [7:0] last;
    logic pgen;
    logic [3:0][7:0] ports;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [15:0] ret_addr;
    logic ret_valid;
    logic ext_valid;
    logic ext_write;
    logic [7:0] ext_addr;
    logic [7:0] ext_page;
    logic [7:0] ext_wdata;
  } dsd_core_t;

  dsd_core_t core_reg;
  dsd_core_t core_next;

  logic ram_we;
  logic [7:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_raddr;
  logic [7:0] ram_rdata;
  logic rec_in_one;
  logic rec_in_two;
  logic rec_out_one;
  logic rec_out_two;
  logic is_sfr;
  logic [7:0] byte_addr;
  logic [2:0] bit_idx;
  logic [7:0] sfr_rd;
  logic sfr_local;
  logic page_ok;
  logic [7:0] old_byte;
  logic [7:0] rval;
  logic [7:0] wval;

  // ************************************************************
  // Address decode
  // ************************************************************
  always_comb
  begin
    bit_idx = acc_addr[2:0];
    // operand type picks bit or byte
    if (acc_bit)
    begin
      // bit addresses from 0x80 are SFR bits
      is_sfr = acc_addr[7];
      // only SFRs ending 0x0 or 0x8 hold bits
      if (acc_addr[7])
        byte_addr = {acc_addr[7:3], 3'b000};
      // bit 8k+n lives in byte 0x20+k
      else
        byte_addr = DSD_BIT_BASE + {4'h0, acc_addr[6:3]};
    end
    else
    begin
      // indirect reaches upper RAM, direct reaches SFRs
      is_sfr = !acc_indirect && acc_addr[7];
      byte_addr = acc_addr;
    end
  end

  // only five pages are backed by registers
  always_comb
  begin
    case (core_reg.page)
      DSD_PAGE_0, DSD_PAGE_1, DSD_PAGE_2, DSD_PAGE_3, DSD_PAGE_F: page_ok = 1'b1;
      default: page_ok = 1'b0;
    endcase
  end

  // these registers ignore the page select value
  always_comb
  begin
    sfr_local = 1'b1;
    case (byte_addr)
      DSD_SP_ADDR: sfr_rd = core_reg.sp;
      DSD_PAGE_ADDR: sfr_rd = core_reg.page;
      DSD_NEXT_ADDR: sfr_rd = core_reg.nxt;
      DSD_LAST_ADDR: sfr_rd = core_reg.last;
      DSD_PGCN_ADDR: sfr_rd = {7'h00, core_reg.pgen};
      DSD_P0_ADDR: sfr_rd = core_reg.ports[0];
      DSD_P1_ADDR: sfr_rd = core_reg.ports[1];
      DSD_P2_ADDR: sfr_rd = core_reg.ports[2];
      DSD_P3_ADDR: sfr_rd = core_reg.ports[3];
      default:
      begin
        sfr_rd = 8'h00;
        sfr_local = 1'b0;
      end
    endcase
  end

  // bit and byte views of the same byte
  always_comb
  begin
    old_byte = is_sfr ? sfr_rd : ram_rdata;
    wval = acc_wdata;
    rval = old_byte;
    if (acc_bit)
    begin
      wval = old_byte;
      wval[bit_idx] = acc_wdata[0];
      rval = {7'h00, old_byte[bit_idx]};
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_comb
  begin
    core_next = core_reg;
    core_next.rd_valid = 1'b0;
    core_next.ret_valid = 1'b0;
    core_next.ext_valid = 1'b0;
    ram_we = 1'b0;
    ram_waddr = 8'h00;
    ram_wdata = 8'h00;
    ram_raddr = byte_addr;
    rec_in_one = 1'b0;
    rec_in_two = 1'b0;
    rec_out_one = 1'b0;
    rec_out_two = 1'b0;
    case (core_reg.state)
      DSD_IDLE:
      begin
        if (stk_call)
        begin
          // Low byte first, high byte next cycle
          ram_we = 1'b1;
          ram_waddr = core_reg.sp + 8'h01;
          ram_wdata = call_addr[7:0];
          core_next.sp = core_reg.sp + 8'h01;
          core_next.ret_addr = call_addr;
          rec_in_two = 1'b1;
          core_next.state = DSD_CALL_HI;
        end
        else if (stk_ret)
        begin
          ram_raddr = core_reg.sp;
          core_next.ret_addr[15:8] = ram_rdata;
          core_next.sp = core_reg.sp - 8'h01;
          rec_out_two = 1'b1;
          core_next.state = DSD_RET_LO;
        end
        else if (stk_push)
        begin
          // write above pointer, then bump it
          ram_we = 1'b1;
          ram_waddr = core_reg.sp + 8'h01;
          ram_wdata = push_data;
          core_next.sp = core_reg.sp + 8'h01;
          rec_in_one = 1'b1;
        end
        else if (stk_pop)
        begin
          ram_raddr = core_reg.sp;
          core_next.rd_data = ram_rdata;
          core_next.rd_valid = 1'b1;
          core_next.sp = core_reg.sp - 8'h01;
          rec_out_one = 1'b1;
        end
        else if (acc_valid && !acc_write)
        begin
          core_next.rd_data = rval;
          core_next.rd_valid = 1'b1;
        end
        else if (acc_valid && !is_sfr)
        begin
          ram_we = 1'b1;
          ram_waddr = byte_addr;
          ram_wdata = wval;
        end
        else if (acc_valid)
        begin
          // plain writes touch one entry, except one-step SP writes
          case (byte_addr)
            DSD_SP_ADDR:
            begin
              // a one-step pointer write also shifts the stack record
              core_next.sp = wval;
              if (wval == core_reg.sp + 8'h01)
                rec_in_one = 1'b1;
              else if (wval == core_reg.sp - 8'h01)
                rec_out_one = 1'b1;
            end
            DSD_PAGE_ADDR: core_next.page = wval;
            DSD_NEXT_ADDR: core_next.nxt = wval;
            DSD_LAST_ADDR: core_next.last = wval;
            DSD_PGCN_ADDR: core_next.pgen = wval[0];
            DSD_P0_ADDR: core_next.ports[0] = wval;
            DSD_P1_ADDR: core_next.ports[1] = wval;
            DSD_P2_ADDR: core_next.ports[2] = wval;
            DSD_P3_ADDR: core_next.ports[3] = wval;
            default: core_next.ports = core_reg.ports;
          endcase
        end
        // Paged registers live outside; unbacked pages are dropped
        if (!stk_call && !stk_ret && !stk_push && !stk_pop && acc_valid && is_sfr
            && !sfr_local && page_ok)
        begin
          core_next.ext_valid = 1'b1;
          core_next.ext_write = acc_write;
          core_next.ext_addr = byte_addr;
          core_next.ext_page = core_reg.page;
          core_next.ext_wdata = wval;
        end
      end
      DSD_CALL_HI:
      begin
        ram_we = 1'b1;
        ram_waddr = core_reg.sp + 8'h01;
        ram_wdata = core_reg.ret_addr[15:8];
        core_next.sp = core_reg.sp + 8'h01;
        core_next.state = DSD_IDLE;
      end
      DSD_RET_LO:
      begin
        ram_raddr = core_reg.sp;
        core_next.ret_addr[7:0] = ram_rdata;
        core_next.sp = core_reg.sp - 8'h01;
        core_next.ret_valid = 1'b1;
        core_next.state = DSD_IDLE;
      end
      default: core_next.state = DSD_IDLE;
    endcase
    // disabled auto paging leaves the stack alone
    if (core_reg.pgen && irq_enter)
    begin
      // push and load the interrupt's page
      // deep nesting drops the oldest page
      core_next.last = core_reg.nxt;
      core_next.nxt = core_reg.page;
      core_next.page = irq_page;
    end
    else if (core_reg.pgen && return_from_interrupt)
    begin
      // pop, bottom refills with empty page
      core_next.page = core_reg.nxt;
      core_next.nxt = core_reg.last;
      core_next.last = DSD_EMPTY_PAGE;
    end
    core_next.busy = core_next.state != DSD_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      core_reg <= '0;
      // pointer starts below register bank 1
      core_reg.sp <= DSD_SP_RST;
      core_reg.page <= DSD_PAGE_RST;
      core_reg.pgen <= DSD_PGEN_RST;
      core_reg.ports <= {4{DSD_PORT_RST}};
      core_reg.state <= DSD_IDLE;
    end
    else
      core_reg <= core_next;
  end

  // ************************************************************
  // Submodules
  // ************************************************************
  dsd_ram u_ram
  (
    .clk(clk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(ram_raddr),
    .rdata(ram_rdata)
  );

  dsd_stkrec u_rec
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_one(rec_in_one),
    .in_two(rec_in_two),
    .out_one(rec_out_one),
    .out_two(rec_out_two),
    .rec_bits(),
    .rec_level(rec_level),
    .rec_overflow(rec_overflow),
    .rec_underflow(rec_underflow)
  );

  assign rd_data = core_reg.rd_data;
  assign rd_valid = core_reg.rd_valid;
  assign ret_addr = core_reg.ret_addr;
  assign ret_valid = core_reg.ret_valid;
  assign busy = core_reg.busy;
  assign stack_pointer = core_reg.sp;
  assign page_select_register = core_reg.page;
  assign page_stack_second_entry = core_reg.nxt;
  assign page_stack_bottom_entry = core_reg.last;
  assign auto_page_enable = core_reg.pgen;
  assign port_zero_data = core_reg.ports[0];
  assign port_one_data = core_reg.ports[1];
  assign port_two_data = core_reg.ports[2];
  assign port_three_data = core_reg.ports[3];
  assign ext_sfr_valid = core_reg.ext_valid;
  assign ext_sfr_write = core_reg.ext_write;
  assign ext_sfr_addr = core_reg.ext_addr;
  assign ext_sfr_page = core_reg.ext_page;
  assign ext_sfr_wdata = core_reg.ext_wdata;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_sp_reset;
    @(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> stack_pointer == DSD_SP_RST && auto_page_enable;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("bad reset values");

  property p_push;
    @(posedge clk) disable iff (sys_rst)
    (!busy && !stk_call && !stk_ret && stk_push) |->
      ram_we && ram_waddr == stack_pointer + 8'h01 ##1 stack_pointer == $past(stack_pointer) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push order wrong");

  property p_bit_map;
    @(posedge clk) disable iff (sys_rst)
    (acc_bit && !acc_addr[7]) |-> byte_addr == DSD_BIT_BASE + {4'h0, acc_addr[6:3]};
  endproperty
  a_bit_map: assert property (p_bit_map) else $error("bit address mapped wrong");

  property p_sp_read;
    @(posedge clk) disable iff (sys_rst)
    (!busy && !stk_call && !stk_ret && !stk_push && !stk_pop && acc_valid && !acc_write
      && !acc_bit && !acc_indirect && acc_addr == DSD_SP_ADDR) |=>
      rd_valid && rd_data == $past(stack_pointer);
  endproperty
  a_sp_read: assert property (p_sp_read) else $error("direct read missed SFR");

  property p_irq_push;
    @(posedge clk) disable iff (sys_rst)
    (irq_enter && auto_page_enable) |=> page_select_register == $past(irq_page)
      && page_stack_second_entry == $past(page_select_register)
      && page_stack_bottom_entry == $past(page_stack_second_entry);
  endproperty
  a_irq_push: assert property (p_irq_push) else $error("page push wrong");

  property p_return_from_interrupt_pop;
    @(posedge clk) disable iff (sys_rst)
    (!irq_enter && return_from_interrupt && auto_page_enable) |=>
      page_select_register == $past(page_stack_second_entry)
      && page_stack_bottom_entry == DSD_EMPTY_PAGE;
  endproperty
  a_return_from_interrupt_pop: assert property (p_return_from_interrupt_pop) else $error("page pop wrong");

  property p_no_auto;
    @(posedge clk) disable iff (sys_rst)
    ((irq_enter || return_from_interrupt) && !auto_page_enable && !acc_valid) |=>
      $stable(page_select_register) && $stable(page_stack_second_entry);
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("page moved while disabled");

  property p_port_any_page;
    @(posedge clk) disable iff (sys_rst)
    (!busy && !stk_call && !stk_ret && !stk_push && !stk_pop && acc_valid && acc_write
      && !acc_bit && !acc_indirect && acc_addr == DSD_P1_ADDR) |=>
      port_one_data == $past(acc_wdata);
  endproperty
  a_port_any_page: assert property (p_port_any_page) else $error("port write lost");

endmodule

// File: test/dsd_irq_model.sv
`timescale 1ns/1ps
// ************************************************************
// Interrupt sequencing partner
// ************************************************************
module dsd_irq_model
(
  input wire logic clk,
  output logic irq_enter,
  output logic [7:0] irq_page,
  output logic return_from_interrupt
);
  initial
  begin
    irq_enter = 1'b0;
    irq_page = 8'h00;
    return_from_interrupt = 1'b0;
  end
  task automatic enter(input logic [7:0] p);
    @(negedge clk);
    irq_enter = 1'b1;
    irq_page = p;
    @(negedge clk);
    irq_enter = 1'b0;
    // Released page bus shows junk, not the last value
    irq_page = ~p;
  endtask
  task automatic leave();
    @(negedge clk);
    return_from_interrupt = 1'b1;
    @(negedge clk);
    return_from_interrupt = 1'b0;
  endtask
endmodule

// File: test/dsd_core_tb_top.sv
`timescale 1ns/1ps
module dsd_core_tb_top;
  import dsd_pkg::*;
  logic clk, sys_rst, acc_valid, acc_write, acc_bit, acc_indirect;
  logic stk_push, stk_pop, stk_call, stk_ret, irq_enter, return_from_interrupt;
  logic [7:0] acc_addr, acc_wdata, push_data, irq_page, rd_data, stack_pointer;
  logic [7:0] page_select_register, page_stack_second_entry, page_stack_bottom_entry;
  logic [7:0] port_one_data, port_zero_data, port_two_data, port_three_data;
  logic [7:0] ext_sfr_addr, ext_sfr_page, ext_sfr_wdata;
  logic ext_sfr_valid, ext_sfr_write;
  logic [15:0] call_addr, ret_addr;
  logic rd_valid, ret_valid, busy, auto_page_enable, rec_overflow, rec_underflow;
  logic [5:0] rec_level;
  int error_cnt = 0;
  int total_checks = 0;
  dsd_core dsd_core_i (.clk(clk), .sys_rst(sys_rst), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_bit(acc_bit), .acc_indirect(acc_indirect),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .stk_push(stk_push), .stk_pop(stk_pop),
    .stk_call(stk_call), .stk_ret(stk_ret), .push_data(push_data), .call_addr(call_addr),
    .irq_enter(irq_enter), .irq_page(irq_page),
    .return_from_interrupt(return_from_interrupt), .rd_data(rd_data),
    .rd_valid(rd_valid), .ret_addr(ret_addr), .ret_valid(ret_valid), .busy(busy),
    .stack_pointer(stack_pointer), .page_select_register(page_select_register),
    .page_stack_second_entry(page_stack_second_entry),
    .page_stack_bottom_entry(page_stack_bottom_entry),
    .auto_page_enable(auto_page_enable), .port_zero_data(port_zero_data),
    .port_one_data(port_one_data), .port_two_data(port_two_data),
    .port_three_data(port_three_data), .ext_sfr_valid(ext_sfr_valid),
    .ext_sfr_write(ext_sfr_write), .ext_sfr_addr(ext_sfr_addr), .ext_sfr_page(ext_sfr_page),
    .ext_sfr_wdata(ext_sfr_wdata), .rec_level(rec_level),
    .rec_overflow(rec_overflow), .rec_underflow(rec_underflow));
  dsd_irq_model dsd_irq_model_i (.clk(clk), .irq_enter(irq_enter), .irq_page(irq_page),
    .return_from_interrupt(return_from_interrupt));
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic acc(input logic w, b, i, input logic [7:0] a, d);
    @(negedge clk);
    {acc_valid, acc_write, acc_bit, acc_indirect} = {1'b1, w, b, i};
    acc_addr = a;
    acc_wdata = d;
    @(negedge clk);
    acc_valid = 1'b0;
  endtask
  task automatic rd(input logic b, i, input logic [7:0] a, exp);
    acc(1'b0, b, i, a, 8'h00);
    chk(rd_valid, 1'b1);
    chk(rd_data, exp);
  endtask
  // Order is call, ret, push, pop
  task automatic stk(input logic [3:0] k, input logic [15:0] v);
    @(negedge clk);
    {stk_call, stk_ret, stk_push, stk_pop} = k;
    push_data = v[7:0];
    call_addr = v;
    @(negedge clk);
    {stk_call, stk_ret, stk_push, stk_pop} = 4'h0;
  endtask
  task automatic pages(input logic [7:0] p, n, l);
    chk(page_select_register, p);
    chk(page_stack_second_entry, n);
    chk(page_stack_bottom_entry, l);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    {sys_rst, acc_valid, acc_write, acc_bit, acc_indirect} = 5'h10;
    {stk_push, stk_pop, stk_call, stk_ret} = 4'h0;
    {acc_addr, acc_wdata, push_data, call_addr} = 40'h0;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    chk(stack_pointer, 8'h07);
    chk(auto_page_enable, 1'b1);
    pages(8'h00, 8'h00, 8'h00);
    rd(1'b0, 1'b0, 8'h81, 8'h07);
    stk(4'h2, 16'h00A5);
    chk(stack_pointer, 8'h08);
    chk(rec_level, 6'h01);
    rd(1'b0, 1'b0, 8'h08, 8'hA5);
    stk(4'h8, 16'h1234);
    @(negedge clk);
    chk(stack_pointer, 8'h0A);
    chk(rec_level, 6'h03);
    stk(4'h4, 16'h0000);
    @(negedge clk);
    chk(ret_valid, 1'b1);
    chk(ret_addr, 16'h1234);
    chk(rec_level, 6'h01);
    stk(4'h1, 16'h0000);
    chk(rd_data, 8'hA5);
    chk(rec_level, 6'h00);
    stk(4'h1, 16'h0000);
    chk(rec_underflow, 1'b1);
    stk(4'h4, 16'h0000);
    chk(rec_underflow, 1'b1);
    repeat (33) stk(4'h2, 16'h0000);
    chk(rec_overflow, 1'b1);
    chk(rec_level, 6'h20);
    $display("test stack done");
    acc(1'b1, 1'b0, 1'b0, 8'h2F, 8'h00);
    acc(1'b1, 1'b0, 1'b0, 8'h22, 8'h00);
    acc(1'b1, 1'b1, 1'b0, 8'h7F, 8'h01);
    acc(1'b1, 1'b1, 1'b0, 8'h13, 8'h01);
    rd(1'b0, 1'b0, 8'h2F, 8'h80);
    rd(1'b0, 1'b0, 8'h22, 8'h08);
    rd(1'b1, 1'b0, 8'h7F, 8'h01);
    $display("test bits done");
    acc(1'b1, 1'b0, 1'b1, 8'h90, 8'h5A);
    rd(1'b0, 1'b1, 8'h90, 8'h5A);
    rd(1'b0, 1'b0, 8'h90, 8'hFF);
    acc(1'b1, 1'b0, 1'b0, 8'h84, 8'h0F);
    rd(1'b0, 1'b0, 8'h90, 8'hFF);
    chk(port_one_data, 8'hFF);
    acc(1'b1, 1'b0, 1'b0, 8'h90, 8'h3C);
    chk(port_one_data, 8'h3C);
    chk({port_two_data, port_three_data}, 16'hFFFF);
    acc(1'b1, 1'b1, 1'b0, 8'h81, 8'h00);
    chk(port_zero_data, 8'hFD);
    acc(1'b1, 1'b0, 1'b0, 8'hD8, 8'h5A);
    chk(ext_sfr_valid, 1'b1);
    chk({7'h00, ext_sfr_write, ext_sfr_addr}, 16'h01D8);
    chk({ext_sfr_page, ext_sfr_wdata}, 16'h0F5A);
    acc(1'b1, 1'b0, 1'b0, 8'h84, 8'h05);
    acc(1'b1, 1'b0, 1'b0, 8'hD8, 8'h11);
    chk(ext_sfr_valid, 1'b0);
    acc(1'b1, 1'b0, 1'b0, 8'h84, 8'h0F);
    $display("test sfr done");
    dsd_irq_model_i.enter(8'h02);
    pages(8'h02, 8'h0F, 8'h00);
    dsd_irq_model_i.enter(8'h00);
    pages(8'h00, 8'h02, 8'h0F);
    dsd_irq_model_i.leave();
    pages(8'h02, 8'h0F, 8'h00);
    acc(1'b1, 1'b0, 1'b0, 8'h86, 8'h03);
    pages(8'h02, 8'h0F, 8'h03);
    dsd_irq_model_i.leave();
    pages(8'h0F, 8'h03, 8'h00);
    dsd_irq_model_i.enter(8'h01);
    dsd_irq_model_i.enter(8'h02);
    dsd_irq_model_i.enter(8'h03);
    pages(8'h03, 8'h02, 8'h01);
    acc(1'b1, 1'b0, 1'b0, 8'h96, 8'h00);
    chk(auto_page_enable, 1'b0);
    dsd_irq_model_i.enter(8'h0F);
    pages(8'h03, 8'h02, 8'h01);
    dsd_irq_model_i.leave();
    pages(8'h03, 8'h02, 8'h01);
    $display("test paging done");
    tally_and_finish();
  end
endmodule
